// ---- design/front_panel_status_controller.sv ----
// Front-panel buttons, status lamps and error blink code for the logger
//
// The Avalon-MM slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module front_panel_status_controller #(
  parameter int STEADY_CYCLES     = panel_pkg::STEADY_CYCLES,
  parameter int BLINK_HALF_CYCLES = panel_pkg::BLINK_HALF_CYCLES
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        usbAttached,
  input  wire logic        cardPresent,
  input  wire logic        cardBusy,
  input  wire logic [4:0]  buttons,
  input  wire logic        triggerCondition,
  input  wire logic        acquisitionDone,
  input  wire logic        eventOccurred,
  input  wire logic [12:0] faultEvent,
  input  wire logic [15:0] digitalInActive,
  input  wire logic [15:0] digitalInVoltage,
  output logic             cardActivityLamp,
  output logic             cardStatusLamp,
  output logic             loggingLamp,
  output logic             acquisitionFiredLamp,
  output logic             eventLamp,
  output logic [15:0]      digitalInLamp,
  output logic             supplyPositiveLamp,
  output logic [15:0]      analogLamp,
  output logic             relayEnergized
);
  localparam int BW = $clog2(BLINK_HALF_CYCLES + 1);
  localparam logic [BW-1:0] BLINK_LAST = BW'(BLINK_HALF_CYCLES - 1);
  localparam logic [BW-1:0] BLINK_LOAD = BW'(BLINK_HALF_CYCLES);

  generate
    if (BLINK_HALF_CYCLES < 2 || STEADY_CYCLES < 1) begin : gCheck
      $error("front_panel_status_controller timing parameters out of range");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Buttons and error holder
  // ----------------------------------------------------------------
  logic [panel_pkg::BTN_COUNT-1:0] press;
  logic                            anyPress;
  err_if                           errBus ();

  button_press #(
    .COUNT (panel_pkg::BTN_COUNT)
  ) uButtons (
    .ref_clk (ref_clk),
    .rst     (rst),
    .level   (buttons),
    .enable  (~usbAttached),
    .press   (press)
  );

  error_code_holder #(
    .STEADY_CYCLES (STEADY_CYCLES),
    .FAULTS        (panel_pkg::FAULT_COUNT)
  ) uErrors (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .faultEvent (faultEvent),
    .err        (errBus.holder)
  );

  // A press that acknowledges an error does nothing else
  assign anyPress = |press;
  logic  ackPress;
  logic  actPress;
  assign ackPress = anyPress & errBus.showing;
  assign actPress = anyPress & ~errBus.showing;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [panel_pkg::CTRL_WIDTH-1:0] ctrl;
  logic [15:0]                      scanList;
  logic [panel_pkg::REQ_WIDTH-1:0]  request;
  logic [panel_pkg::REQ_WIDTH-1:0]  reqSet;
  logic                             accessDone;
  logic                             wrTake;
  logic [1:0]                       regSel;
  logic                             mapped;
  logic                             configValid;
  logic                             eventRec;
  logic                             relayArm;

  assign regSel          = avs_address[3:2];
  assign mapped          = (avs_address[1:0] == 2'h0);
  assign avs_waitrequest = (avs_read | avs_write) & ~accessDone;
  assign wrTake          = avs_write & accessDone & mapped;
  assign configValid     = ctrl[panel_pkg::CTRL_CONFIG_VALID];
  assign eventRec        = ctrl[panel_pkg::CTRL_EVENT_REC];
  assign relayArm        = ctrl[panel_pkg::CTRL_RELAY_ARM];

  // ----------------------------------------------------------------
  // Logging state
  // ----------------------------------------------------------------
  panel_pkg::log_state_t  logState;
  panel_pkg::log_state_t  next_logState;
  panel_pkg::lamp_mode_t  lampMode;
  panel_pkg::lamp_mode_t  next_lampMode;
  logic startPress;
  logic firePress;
  logic opPress;
  logic canStart;
  logic forceFire;
  logic addEvent;

  assign startPress = actPress & press[panel_pkg::BTN_START];
  assign firePress  = actPress & press[panel_pkg::BTN_FIRE];
  assign opPress    = actPress & (press[panel_pkg::BTN_SAVE] | press[panel_pkg::BTN_LOAD]
                                  | (press[panel_pkg::BTN_START] & logState == panel_pkg::LOG_IDLE));
  assign canStart   = cardPresent & configValid & ~usbAttached;
  assign forceFire  = firePress & (logState == panel_pkg::LOG_WAITING);
  assign addEvent   = firePress & eventRec & (logState != panel_pkg::LOG_IDLE);

  assign errBus.missingCard = opPress & ~cardPresent;
  assign errBus.ack         = ackPress;

  always_comb begin
    next_logState = logState;
    case (logState)
      panel_pkg::LOG_IDLE: begin
        if (startPress & canStart) begin
          next_logState = panel_pkg::LOG_WAITING;
        end
      end
      panel_pkg::LOG_WAITING: begin
        if (startPress) begin
          next_logState = panel_pkg::LOG_IDLE;
        end else if (triggerCondition | forceFire) begin
          next_logState = panel_pkg::LOG_ACQUIRING;
        end
      end
      panel_pkg::LOG_ACQUIRING: begin
        if (startPress | acquisitionDone) begin
          next_logState = panel_pkg::LOG_IDLE;
        end
      end
      default: begin
        next_logState = panel_pkg::LOG_IDLE;
      end
    endcase
  end

  always_comb begin
    next_lampMode = lampMode;
    if (actPress & press[panel_pkg::BTN_CYCLE]) begin
      case (lampMode)
        panel_pkg::LAMPS_ALL:  next_lampMode = panel_pkg::LAMPS_TOP;
        panel_pkg::LAMPS_TOP:  next_lampMode = panel_pkg::LAMPS_NONE;
        panel_pkg::LAMPS_NONE: next_lampMode = panel_pkg::LAMPS_ALL;
        default:               next_lampMode = panel_pkg::LAMPS_ALL;
      endcase
    end
  end

  // Requests for firmware; a new press wins over a clear
  assign reqSet[panel_pkg::REQ_START] = startPress & canStart & (logState == panel_pkg::LOG_IDLE);
  assign reqSet[panel_pkg::REQ_STOP]  = startPress & (logState != panel_pkg::LOG_IDLE);
  assign reqSet[panel_pkg::REQ_SAVE]  = actPress & press[panel_pkg::BTN_SAVE] & cardPresent;
  assign reqSet[panel_pkg::REQ_LOAD]  = actPress & press[panel_pkg::BTN_LOAD] & cardPresent;
  assign reqSet[panel_pkg::REQ_FORCE] = forceFire;
  assign reqSet[panel_pkg::REQ_EVENT] = addEvent;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      logState <= panel_pkg::LOG_IDLE;
      lampMode <= panel_pkg::LAMPS_ALL;
    end else begin
      logState <= next_logState;
      lampMode <= next_lampMode;
    end
  end

  // ----------------------------------------------------------------
  // Bus slave: one wait state, then answer
  // ----------------------------------------------------------------
  logic [31:0] readValue;
  logic [31:0] statusWord;

  assign statusWord = {20'h0_0000, errBus.code, 1'b0, errBus.showing, 2'(lampMode),
                       2'(logState), cardPresent, usbAttached};
  assign readValue  = !mapped ? 32'h0000_0000 :
                      (regSel == panel_pkg::REG_CTRL)    ? {29'h0, ctrl} :
                      (regSel == panel_pkg::REG_SCAN)    ? {16'h0000, scanList} :
                      (regSel == panel_pkg::REG_REQUEST) ? {26'h0, request} :
                      statusWord;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      accessDone   <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      accessDone   <= (avs_read | avs_write) & ~accessDone;
      if (avs_read & ~accessDone) begin
        avs_readdata <= readValue;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl     <= panel_pkg::CTRL_RESET;
      scanList <= panel_pkg::SCAN_RESET;
    end else if (wrTake) begin
      if (regSel == panel_pkg::REG_CTRL && avs_byteenable[0]) begin
        ctrl <= avs_writedata[panel_pkg::CTRL_WIDTH-1:0];
      end
      if (regSel == panel_pkg::REG_SCAN) begin
        if (avs_byteenable[0]) begin
          scanList[7:0] <= avs_writedata[7:0];
        end
        if (avs_byteenable[1]) begin
          scanList[15:8] <= avs_writedata[15:8];
        end
      end
    end
  end

  // Write one to clear; set beats clear
  logic [panel_pkg::REQ_WIDTH-1:0] reqClear;
  assign reqClear = (wrTake && regSel == panel_pkg::REG_REQUEST && avs_byteenable[0]) ?
                    avs_writedata[panel_pkg::REQ_WIDTH-1:0] : '0;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      request <= '0;
    end else begin
      request <= reqSet | (request & ~reqClear);
    end
  end

  // ----------------------------------------------------------------
  // Blink timing
  // ----------------------------------------------------------------
  logic [BW-1:0] blinkCount;
  logic          blinkPhase;
  logic [BW-1:0] eventTimer;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      blinkCount <= '0;
      blinkPhase <= 1'b0;
    end else if (blinkCount == BLINK_LAST) begin
      blinkCount <= '0;
      blinkPhase <= ~blinkPhase;
    end else begin
      blinkCount <= blinkCount + BW'(1);
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      eventTimer <= '0;
    end else if (eventOccurred | addEvent) begin
      eventTimer <= BLINK_LOAD;
    end else if (eventTimer != '0) begin
      eventTimer <= eventTimer - BW'(1);
    end
  end

  // ----------------------------------------------------------------
  // Lamp composition
  // ----------------------------------------------------------------
  logic        topOn;
  logic        terminalOn;
  logic [3:0]  codeBits;
  logic [15:0] codeMask;
  logic [15:0] codeLit;
  logic [15:0] next_analog;

  assign topOn      = ~usbAttached & (lampMode != panel_pkg::LAMPS_NONE);
  assign terminalOn = ~usbAttached & (lampMode == panel_pkg::LAMPS_ALL);
  assign codeBits   = errBus.showing ? errBus.code : 4'h0;

  always_comb begin
    codeMask = 16'h0000;
    codeLit  = 16'h0000;
    codeMask[panel_pkg::CODE_LAMP_A0] = errBus.showing;
    codeMask[panel_pkg::CODE_LAMP_A1] = errBus.showing;
    codeMask[panel_pkg::CODE_LAMP_A2] = errBus.showing;
    codeMask[panel_pkg::CODE_LAMP_A3] = errBus.showing;
    codeMask[panel_pkg::CODE_LAMP_B0] = errBus.showing;
    codeMask[panel_pkg::CODE_LAMP_B1] = errBus.showing;
    codeMask[panel_pkg::CODE_LAMP_B2] = errBus.showing;
    codeMask[panel_pkg::CODE_LAMP_B3] = errBus.showing;
    codeLit[panel_pkg::CODE_LAMP_A0]  = codeBits[0];
    codeLit[panel_pkg::CODE_LAMP_A1]  = codeBits[1];
    codeLit[panel_pkg::CODE_LAMP_A2]  = codeBits[2];
    codeLit[panel_pkg::CODE_LAMP_A3]  = codeBits[3];
    codeLit[panel_pkg::CODE_LAMP_B0]  = codeBits[3];
    codeLit[panel_pkg::CODE_LAMP_B1]  = codeBits[2];
    codeLit[panel_pkg::CODE_LAMP_B2]  = codeBits[1];
    codeLit[panel_pkg::CODE_LAMP_B3]  = codeBits[0];
  end

  assign next_analog = ((scanList & ~codeMask) | (codeLit & {16{blinkPhase}}))
                       & {16{terminalOn}};

  logic next_relay;
  assign next_relay = relayArm & (logState == panel_pkg::LOG_ACQUIRING);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cardActivityLamp     <= 1'b0;
      cardStatusLamp       <= 1'b0;
      loggingLamp          <= 1'b0;
      acquisitionFiredLamp <= 1'b0;
      eventLamp            <= 1'b0;
      digitalInLamp        <= 16'h0000;
      supplyPositiveLamp   <= 1'b0;
      analogLamp           <= 16'h0000;
      relayEnergized       <= 1'b0;
    end else begin
      cardActivityLamp     <= topOn & cardBusy & blinkPhase;
      cardStatusLamp       <= topOn & (errBus.steadyOn | (errBus.showing & blinkPhase));
      loggingLamp          <= topOn & (logState != panel_pkg::LOG_IDLE);
      acquisitionFiredLamp <= topOn & (logState == panel_pkg::LOG_ACQUIRING);
      eventLamp            <= topOn & (eventTimer != '0);
      digitalInLamp        <= digitalInActive & digitalInVoltage & {16{terminalOn}};
      supplyPositiveLamp   <= terminalOn & next_relay;
      analogLamp           <= next_analog;
      relayEnergized       <= next_relay;
    end
  end
endmodule

// ---- design/panel_pkg.sv ----
// Shared constants and types for the front-panel status controller
// How it works
// - With a USB host attached, buttons are ignored and all lamps stay dark.
// - Card activity lamp blinks while the storage card is being read or written.
// - Operation requested without a card lights the status lamp steadily one second.
// - Status lamp blinks for card, drive, configuration or overrun errors.
// - While an error shows, two groups of four lamps blink the code.
// - Any button press acknowledges the error and stops the blinking.
// - Codes: 0001 missing card, 0010 not mounted, 0011 write protected.
// - Codes: 0110 pacer, 0111 buffer, 1000 event overrun.
// - Codes: 1001 transfer engine, 1010 card full, 1011 file at maximum size.
// - Codes: 1100 logging configuration error, 1101 configuration wrong for variant.
// - Logging lamp lit while logging, dark while idle.
// - Acquisition-fired lamp switches on when the acquisition triggers.
// - Event lamp emits one blink per event.
// - Cycle button steps all lamps, top lamps only, none, back to all.
// - Fire button forces a trigger only while logging waits for trigger.
// - Fire button adds an event entry while event recording is active.
// - Start begins logging with card, valid configuration, no host; stops when logging.
// - Save button requests writing the configuration to the card.
// - Load button requests reading and applying the latest configuration.
// - Each digital input lamp lit while voltage seen on its active input.
// - Supply terminal lamp lit whenever the alarm relay is energized.
// - Analog terminal lamp lit when its channel is in the scan list; code lamps show the code while an error shows.
// - Relay energizes only when trigger condition met and data is recorded; here it follows LOG_ACQUIRING (relay armed), forced trigger included.
package panel_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ             = 50_000_000;
  localparam int STEADY_TIME_MS     = 1000;
  localparam int STEADY_CYCLES      = CLK_HZ / 1000 * STEADY_TIME_MS;
  localparam int BLINK_HALF_MS      = 250;
  localparam int BLINK_HALF_CYCLES  = CLK_HZ / 1000 * BLINK_HALF_MS;

  // ----------------------------------------------------------------
  // Error codes, fault input order
  // ----------------------------------------------------------------
  localparam logic [3:0] ERR_CARD_MISSING     = 4'h1;
  localparam logic [3:0] ERR_CARD_UNMOUNTED   = 4'h2;
  localparam logic [3:0] ERR_CARD_PROTECTED   = 4'h3;
  localparam logic [3:0] ERR_FILE_SYSTEM      = 4'h4;
  localparam logic [3:0] ERR_FLASH_WRITE      = 4'h5;
  localparam logic [3:0] ERR_OVERRUN_PACER    = 4'h6;
  localparam logic [3:0] ERR_OVERRUN_BUFFER   = 4'h7;
  localparam logic [3:0] ERR_OVERRUN_EVENTS   = 4'h8;
  localparam logic [3:0] ERR_TRANSFER_ENGINE  = 4'h9;
  localparam logic [3:0] ERR_CARD_FULL        = 4'hA;
  localparam logic [3:0] ERR_FILE_MAX_SIZE    = 4'hB;
  localparam logic [3:0] ERR_LOG_CONFIG       = 4'hC;
  localparam logic [3:0] ERR_CONFIG_VARIANT   = 4'hD;
  localparam int         FAULT_COUNT          = 13;
  localparam logic [3:0] FAULT_CODE_TABLE [0:FAULT_COUNT-1] = '{
    ERR_CARD_MISSING, ERR_CARD_UNMOUNTED, ERR_CARD_PROTECTED, ERR_FILE_SYSTEM,
    ERR_FLASH_WRITE, ERR_OVERRUN_PACER, ERR_OVERRUN_BUFFER, ERR_OVERRUN_EVENTS,
    ERR_TRANSFER_ENGINE, ERR_CARD_FULL, ERR_FILE_MAX_SIZE, ERR_LOG_CONFIG,
    ERR_CONFIG_VARIANT};

  // ----------------------------------------------------------------
  // Code lamp positions in the analog lamp vector
  // ----------------------------------------------------------------
  localparam int CODE_LAMP_A0 = 0;
  localparam int CODE_LAMP_A1 = 8;
  localparam int CODE_LAMP_A2 = 1;
  localparam int CODE_LAMP_A3 = 9;
  localparam int CODE_LAMP_B0 = 6;
  localparam int CODE_LAMP_B1 = 14;
  localparam int CODE_LAMP_B2 = 7;
  localparam int CODE_LAMP_B3 = 15;
  localparam int ANALOG_LAMPS = 16;
  localparam int DIGITAL_LAMPS = 16;

  // ----------------------------------------------------------------
  // Buttons and requests
  // ----------------------------------------------------------------
  localparam int BTN_CYCLE = 0;
  localparam int BTN_FIRE  = 1;
  localparam int BTN_START = 2;
  localparam int BTN_SAVE  = 3;
  localparam int BTN_LOAD  = 4;
  localparam int BTN_COUNT = 5;

  localparam int REQ_START = 0;
  localparam int REQ_STOP  = 1;
  localparam int REQ_SAVE  = 2;
  localparam int REQ_LOAD  = 3;
  localparam int REQ_FORCE = 4;
  localparam int REQ_EVENT = 5;
  localparam int REQ_WIDTH = 6;

  // ----------------------------------------------------------------
  // Register map (word index taken from avs_address[3:2]) and fields
  // ----------------------------------------------------------------
  localparam logic [1:0]  REG_CTRL    = 2'h0;
  localparam logic [1:0]  REG_SCAN    = 2'h1;
  localparam logic [1:0]  REG_REQUEST = 2'h2;
  localparam logic [1:0]  REG_STATUS  = 2'h3;
  localparam int          CTRL_CONFIG_VALID = 0;
  localparam int          CTRL_EVENT_REC    = 1;
  localparam int          CTRL_RELAY_ARM    = 2;
  localparam int          CTRL_WIDTH        = 3;
  localparam logic [2:0]  CTRL_RESET        = 3'h0;
  localparam logic [15:0] SCAN_RESET        = 16'h0000;

  typedef enum {LOG_IDLE, LOG_WAITING, LOG_ACQUIRING} log_state_t;
  typedef enum {LAMPS_ALL, LAMPS_TOP, LAMPS_NONE} lamp_mode_t;

endpackage

// ---- design/err_if.sv ----
// Error display handshake between the panel top and the error holder
`timescale 1ns/1ps
interface err_if;
  logic       missingCard;
  logic       ack;
  logic       showing;
  logic [3:0] code;
  logic       steadyOn;

  modport holder (input missingCard, input ack, output showing, output code, output steadyOn);
  modport user   (output missingCard, output ack, input showing, input code, input steadyOn);
endinterface

// ---- design/button_press.sv ----
// Press detector for the front-panel buttons
`timescale 1ns/1ps
module button_press #(
  parameter int COUNT = panel_pkg::BTN_COUNT
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic [COUNT-1:0] level,
  input  wire logic             enable,
  output logic      [COUNT-1:0] press
);
  logic [COUNT-1:0] prior;

  generate
    if (COUNT < 1) begin : gCheck
      $error("button_press needs at least one button");
    end
  endgenerate

  assign press = level & ~prior & {COUNT{enable}};

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prior <= '0;
    end else begin
      prior <= level;
    end
  end
endmodule

// ---- design/error_code_holder.sv ----
// Latches the error code shown on the panel and times the steady lamp
`timescale 1ns/1ps
module error_code_holder #(
  parameter int STEADY_CYCLES = panel_pkg::STEADY_CYCLES,
  parameter int FAULTS        = panel_pkg::FAULT_COUNT
) (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic [FAULTS-1:0] faultEvent,
  err_if.holder                  err
);
  localparam int TW = $clog2(STEADY_CYCLES + 1);
  localparam logic [TW-1:0] STEADY_LOAD = TW'(STEADY_CYCLES);

  logic [TW-1:0] timer;
  logic          anyFault;
  logic [3:0]    firstCode;

  generate
    if (STEADY_CYCLES < 1 || FAULTS < 1 || FAULTS > panel_pkg::FAULT_COUNT) begin : gCheck
      $error("error_code_holder parameters out of range");
    end
  endgenerate

  // Lowest fault index wins
  function automatic logic [3:0] pick(input logic [FAULTS-1:0] f);
    logic [3:0] c;
    c = 4'h0;
    for (int i = FAULTS - 1; i >= 0; i--) begin
      if (f[i]) begin
        c = panel_pkg::FAULT_CODE_TABLE[i];
      end
    end
    return c;
  endfunction

  assign anyFault     = |faultEvent;
  assign firstCode    = pick(faultEvent);
  assign err.steadyOn = (timer != '0);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      err.showing <= 1'b0;
      err.code    <= 4'h0;
    end else if (err.showing) begin
      if (err.ack) begin
        err.showing <= 1'b0;
      end
    end else if (anyFault) begin
      err.showing <= 1'b1;
      err.code    <= firstCode;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      timer <= '0;
    end else if (err.missingCard) begin
      timer <= STEADY_LOAD;
    end else if (timer != '0) begin
      timer <= timer - TW'(1);
    end
  end
endmodule

// ---- test/panel_checker.sv ----
// Port-level assertions for the front-panel controller
`timescale 1ns/1ps
module panel_checker #(
  parameter int STEADY_CYCLES     = 20,
  parameter int BLINK_HALF_CYCLES = 4
) (
  input wire logic        ref_clk, rst, usbAttached, cardBusy, avs_read, avs_waitrequest,
  input wire logic        cardActivityLamp, loggingLamp, acquisitionFiredLamp,
  input wire logic        supplyPositiveLamp, relayEnergized,
  input wire logic [3:0]  avs_address,
  input wire logic [31:0] avs_readdata,
  input wire logic [15:0] digitalInActive, digitalInVoltage, digitalInLamp
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  chk_usb_dark: assert property (usbAttached |=> !loggingLamp && !cardActivityLamp)
    else $error("lamp lit with host attached");
  chk_act_idle: assert property (!cardBusy |=> !cardActivityLamp)
    else $error("activity lamp lit while card idle");
  chk_wait_first: assert property ($rose(avs_read) |-> avs_waitrequest)
    else $error("read answered without wait state");
  chk_wait_one: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
    else $error("read wait longer than one cycle");
  chk_unmapped_zero: assert property (avs_read && !avs_waitrequest
    && avs_address[1:0] != 2'h0 |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  chk_din_lamp: assert property (1'b1 |=> (digitalInLamp & ~($past(digitalInActive)
    & $past(digitalInVoltage))) == 16'h0)
    else $error("input lamp lit without voltage");
  chk_fired_log: assert property (acquisitionFiredLamp |-> loggingLamp)
    else $error("fired lamp lit while idle");
  chk_supply_relay: assert property (supplyPositiveLamp |-> relayEnergized)
    else $error("supply lamp without relay");
endmodule
bind front_panel_status_controller panel_checker #(.STEADY_CYCLES(STEADY_CYCLES),
  .BLINK_HALF_CYCLES(BLINK_HALF_CYCLES)) panel_checker_i (.ref_clk, .rst, .usbAttached,
  .cardBusy, .avs_read, .avs_waitrequest, .cardActivityLamp, .loggingLamp,
  .acquisitionFiredLamp, .supplyPositiveLamp, .relayEnergized, .avs_address, .avs_readdata,
  .digitalInActive, .digitalInVoltage, .digitalInLamp);

// ---- test/operator_model.sv ----
// Operator holding front-panel buttons down
`timescale 1ns/1ps
module operator_model (
  input  wire logic       ref_clk,
  input  wire logic [4:0] pressReq,
  output logic      [4:0] buttons
);
  logic [2:0] hold = 3'h0;
  initial buttons = 5'h0;
  always @(posedge ref_clk) begin
    if (pressReq != 5'h0) begin
      buttons <= pressReq;
      hold    <= 3'h3;
    end else if (hold != 3'h0) hold <= hold - 3'h1;
    else buttons <= 5'h0;
  end
endmodule

// ---- test/tb.sv ----
// Self-checking bench for the front-panel controller
`timescale 1ns/1ps
module tb;
  logic        ref_clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic        usbAttached = 1'b0, cardPresent = 1'b0, avs_waitrequest, cardActivityLamp;
  logic        cardStatusLamp, loggingLamp, acquisitionFiredLamp, eventLamp;
  logic        supplyPositiveLamp, relayEnergized, cardBusy = 1'b0, eventOccurred = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic [4:0]  pressReq = 5'h0, buttons;
  logic [12:0] faultEvent = 13'h0;
  logic [15:0] digitalInActive = 16'h00ff, digitalInVoltage = 16'h0f0f, digitalInLamp, analogLamp;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rdata;
  int          bad_count = 0, checks_done = 0;
  always #10 ref_clk = ~ref_clk;
  front_panel_status_controller #(.STEADY_CYCLES(20), .BLINK_HALF_CYCLES(4))
    front_panel_status_controller_i (.ref_clk, .rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .usbAttached,
    .cardPresent, .cardBusy, .buttons, .triggerCondition(1'b0), .acquisitionDone(1'b0),
    .eventOccurred, .faultEvent, .digitalInActive, .digitalInVoltage, .cardActivityLamp,
    .cardStatusLamp, .loggingLamp, .acquisitionFiredLamp, .eventLamp, .digitalInLamp,
    .supplyPositiveLamp, .analogLamp, .relayEnergized);
  operator_model operator_model_i (.ref_clk, .pressReq, .buttons);
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(logic wr, logic [3:0] a, logic [31:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    rdata = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic press(logic [4:0] b);
    @(posedge ref_clk) pressReq <= b;
    @(posedge ref_clk) pressReq <= 5'h0;
    repeat (8) @(negedge ref_clk);
  endtask
  task automatic pulse(logic [12:0] f);
    @(posedge ref_clk) faultEvent <= f;
    @(posedge ref_clk) faultEvent <= 13'h0;
  endtask
  task automatic t_regs;
    bus(0, 4'h0, 0);
    chk("ctrl reset", rdata, 0);
    bus(1, 4'h0, 32'h7);
    bus(0, 4'h0, 0);
    chk("ctrl", rdata, 32'h7);
    bus(1, 4'h4, 32'h0000_a5c3);
    bus(0, 4'h1, 0);
    chk("unmapped", rdata, 0);
    chk("scan lamps", analogLamp, 16'ha5c3);
    bus(1, 4'h4, 0);
    @(posedge ref_clk) {cardBusy, eventOccurred} <= 2'h3;
    @(posedge ref_clk) eventOccurred <= 1'b0;
    rdata = 0;
    repeat (8) @(negedge ref_clk) rdata |= {eventLamp, cardActivityLamp};
    chk("event activity", rdata, 3);
    @(posedge ref_clk) cardBusy <= 1'b0;
  endtask
  task automatic t_log;
    @(posedge ref_clk) cardPresent <= 1'b1;
    press(5'h04);
    bus(0, 4'hc, 0);
    chk("waiting", {loggingLamp, rdata[30:0]}, 32'h8000_0006);
    press(5'h02);
    chk("fired", {acquisitionFiredLamp, relayEnergized, supplyPositiveLamp}, 3'h7);
    bus(0, 4'h8, 0);
    chk("force event", rdata & 32'h30, 32'h30);
    press(5'h04);
    chk("stopped", {loggingLamp, relayEnergized}, 0);
    bus(1, 4'h8, 32'h3f);
    press(5'h08);
    press(5'h10);
    bus(0, 4'h8, 0);
    chk("save load", rdata, 32'hc);
    @(posedge ref_clk) cardPresent <= 1'b0;
    press(5'h04);
    chk("steady", {cardStatusLamp, loggingLamp}, 2'h2);
    repeat (20) @(negedge ref_clk);
    chk("steady off", cardStatusLamp, 0);
  endtask
  task automatic t_err;
    logic [3:0]  c;
    logic [16:0] seen;
    for (int i = 0; i < 13; i++) begin
      c = 4'(i + 1);
      pulse(13'h1 << i);
      pulse(13'h1000);
      seen = 17'h0;
      repeat (9) begin
        @(negedge ref_clk);
        seen |= {cardStatusLamp, analogLamp};
      end
      chk("code lamps", seen, {1'b1, c[0], c[2], 4'h0, c[3], c[1], c[1], c[3], 4'h0, c[2], c[0]});
      bus(0, 4'hc, 0);
      chk("code", rdata, {c, 8'h40});
      press(5'h01);
      bus(0, 4'hc, 0);
      chk("acknowledged", rdata, {c, 8'h00});
    end
  endtask
  task automatic t_cycle;
    press(5'h01);
    bus(0, 4'hc, 0);
    chk("top only", {rdata[5:4], digitalInLamp}, 18'h1_0000);
    press(5'h01);
    bus(0, 4'hc, 0);
    chk("none", rdata, 32'hd20);
    press(5'h01);
    chk("all", digitalInLamp, 16'h000f);
    @(posedge ref_clk) usbAttached <= 1'b1;
    @(posedge ref_clk) cardPresent <= 1'b1;
    press(5'h04);
    chk("host", {loggingLamp, digitalInLamp}, 0);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    summarize;
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    t_regs;
    t_log;
    t_err;
    t_cycle;
    summarize;
  end
endmodule
